// *** include/iex_exec_regs.vh ***
// opcode, flag, cycle count and stack constants of the instruction execute unit
`ifndef IEX_EXEC_REGS_VH
`define IEX_EXEC_REGS_VH

// ----------------------------------------------------------------
// prefix and first-table opcodes
// ----------------------------------------------------------------
`define IEX_PREFIX_BYTE 8'h1f
`define IEX_OP_WSUB_WW 8'h28
`define IEX_OP_WSUB_WL 8'h29
`define IEX_OP_SWAP_D 8'hf0
`define IEX_OP_SWAP_P 8'hf1
`define IEX_OP_TCPL_FIRST 8'h62
`define IEX_OP_TCPL_LAST 8'h67
`define IEX_OP_WTCPL_WW 8'h68
`define IEX_OP_WTCPL_WL 8'h69
`define IEX_OP_TMSK_FIRST 8'h72
`define IEX_OP_TMSK_LAST 8'h77
`define IEX_OP_WTMSK_WW 8'h78
`define IEX_OP_WTMSK_WL 8'h79
`define IEX_OP_VCALL 8'hf2

// ----------------------------------------------------------------
// second-table opcodes (after the prefix byte)
// ----------------------------------------------------------------
`define IEX_OP2_PUSH_LIT 8'h70
`define IEX_OP2_CMPC_FIRST 8'ha2
`define IEX_OP2_CMPC_LAST 8'ha7
`define IEX_OP2_WCMPC_WW 8'ha8
`define IEX_OP2_WCMPC_WL 8'ha9
`define IEX_OP2_LSR_D 8'hc0
`define IEX_OP2_LSR_P 8'hc1
`define IEX_OP2_WLOAD 8'he8

// ----------------------------------------------------------------
// addressing form: low opcode nibble bits
// ----------------------------------------------------------------
`define IEX_FORM_SHORT_HI 3'h3
`define IEX_FORM_ODD_BIT 0

// ----------------------------------------------------------------
// flag byte bit positions
// ----------------------------------------------------------------
`define IEX_FLAG_C 7
`define IEX_FLAG_Z 6
`define IEX_FLAG_S 5
`define IEX_FLAG_V 4
`define IEX_FLAG_D 3
`define IEX_FLAG_H 2

// ----------------------------------------------------------------
// fetch and execute cycle counts
// ----------------------------------------------------------------
`define IEX_CYC_0 3'h0
`define IEX_CYC_1 3'h1
`define IEX_CYC_2 3'h2
`define IEX_CYC_3 3'h3
`define IEX_CYC_4 3'h4
`define IEX_CYC_5 3'h5
`define IEX_CYC_6 3'h6

// ----------------------------------------------------------------
// stack pointer steps and vector call and literal push write slots
// ----------------------------------------------------------------
`define IEX_SP_STEP1 16'h0001
`define IEX_SP_STEP2 16'h0002
`define IEX_SP_STEP3 16'h0003
`define IEX_SLOT_PCL 3'h5
`define IEX_SLOT_PCH 3'h4
`define IEX_SLOT_FLAGS 3'h3
`define IEX_SLOT_PUSH 3'h1

// ----------------------------------------------------------------
// misc
// ----------------------------------------------------------------
`define IEX_ZERO8 8'h00
`define IEX_ZERO16 16'h0000
`define IEX_ST_IDLE 1'b0
`define IEX_ST_EXEC 1'b1

`endif

// *** hdl/iex_exec.v ***
// decode and execute unit for a subset of an 8-bit cpu instruction set
`timescale 1ns/1ps
`include "iex_exec_regs.vh"

module iex_exec (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // instruction request
  input wire req_i,
  input wire prefix_i,
  input wire [7:0] opcode_i,
  input wire [15:0] dst_i,
  input wire [15:0] src_i,
  input wire [7:0] flags_i,
  input wire [15:0] pc_i,
  input wire [15:0] sp_i,
  input wire [15:0] vector_pc_i,
  // status
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg [2:0] fetch_cyc_o,
  output reg [2:0] exec_cyc_o,
  // write-back
  output reg [15:0] result_o,
  output reg dst_we_o,
  output reg word_we_o,
  output reg [7:0] flags_o,
  output reg flags_we_o,
  output reg [15:0] pc_o,
  output reg pc_we_o,
  output reg [15:0] sp_o,
  output reg sp_we_o,
  // stack memory write
  output reg mem_we_o,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_data_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg state_ff;
  reg [2:0] cnt_ff;
  reg vcall_ff;
  reg push_ff;
  reg dst_wr_ff;
  reg word_wr_ff;
  reg flg_wr_ff;
  reg [7:0] old_flags_ff;
  reg [15:0] old_pc_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  reg [15:0] nxt_res;
  reg [7:0] nxt_flags;
  reg [2:0] nxt_fcyc;
  reg [2:0] nxt_ecyc;
  reg nxt_legal;
  reg nxt_dst_wr;
  reg nxt_word_wr;
  reg nxt_flg_wr;
  reg nxt_vcall;
  reg nxt_push;
  reg [8:0] diff;
  reg [4:0] hdiff;
  reg [7:0] mask;
  wire [7:0] d = dst_i[7:0];
  wire [7:0] s = src_i[7:0];
  wire cin = flags_i[`IEX_FLAG_C];
  wire short_form = (opcode_i[3:1] == `IEX_FORM_SHORT_HI >> 1) ? 1'b1 : 1'b0;
  wire odd_form = opcode_i[`IEX_FORM_ODD_BIT];

  always @* begin
    nxt_res = `IEX_ZERO16;
    nxt_flags = flags_i;
    nxt_fcyc = `IEX_CYC_0;
    nxt_ecyc = `IEX_CYC_0;
    nxt_legal = 1'b1;
    nxt_dst_wr = 1'b0;
    nxt_word_wr = 1'b0;
    nxt_flg_wr = 1'b0;
    nxt_vcall = 1'b0;
    nxt_push = 1'b0;
    diff = {1'b0, d} - {1'b0, s};
    hdiff = {1'b0, d[3:0]} - {1'b0, s[3:0]};
    mask = d & s;
    if (prefix_i) begin
      if (opcode_i >= `IEX_OP2_CMPC_FIRST && opcode_i <= `IEX_OP2_WCMPC_WL) begin
        diff = {1'b0, d} - {1'b0, s} - {8'h00, cin};
        nxt_flg_wr = 1'b1;
        nxt_flags[`IEX_FLAG_C] = diff[8];
        nxt_flags[`IEX_FLAG_Z] = (diff[7:0] == `IEX_ZERO8) & flags_i[`IEX_FLAG_Z];
        nxt_flags[`IEX_FLAG_S] = diff[7];
        nxt_flags[`IEX_FLAG_V] = (d[7] ^ s[7]) & (diff[7] ^ d[7]);
        nxt_ecyc = odd_form ? `IEX_CYC_4 : `IEX_CYC_3;
        nxt_fcyc = short_form ? `IEX_CYC_3 : `IEX_CYC_4;
        if (opcode_i >= `IEX_OP2_WCMPC_WW) begin
          nxt_fcyc = `IEX_CYC_5;
          nxt_ecyc = `IEX_CYC_3;
        end
      end else if (opcode_i == `IEX_OP2_LSR_D || opcode_i == `IEX_OP2_LSR_P) begin
        nxt_res = {8'h00, 1'b0, d[7:1]};
        nxt_dst_wr = 1'b1;
        nxt_flg_wr = 1'b1;
        nxt_flags[`IEX_FLAG_C] = d[0];
        nxt_flags[`IEX_FLAG_Z] = (d[7:1] == 7'h00);
        nxt_flags[`IEX_FLAG_S] = 1'b0;
        nxt_flags[`IEX_FLAG_V] = 1'b0;
        nxt_fcyc = `IEX_CYC_3;
        nxt_ecyc = odd_form ? `IEX_CYC_3 : `IEX_CYC_2;
      end else if (opcode_i == `IEX_OP2_PUSH_LIT) begin
        nxt_push = 1'b1;
        nxt_fcyc = `IEX_CYC_3;
        nxt_ecyc = `IEX_CYC_2;
      end else if (opcode_i == `IEX_OP2_WLOAD) begin
        nxt_res = src_i;
        nxt_word_wr = 1'b1;
        nxt_fcyc = `IEX_CYC_5;
        nxt_ecyc = `IEX_CYC_4;
      end else begin
        nxt_legal = 1'b0;
      end
    end else if (opcode_i == `IEX_OP_WSUB_WW || opcode_i == `IEX_OP_WSUB_WL) begin
      nxt_res = {8'h00, diff[7:0]};
      nxt_dst_wr = 1'b1;
      nxt_flg_wr = 1'b1;
      nxt_fcyc = `IEX_CYC_4;
      nxt_ecyc = `IEX_CYC_3;
      nxt_flags[`IEX_FLAG_C] = diff[8];
      nxt_flags[`IEX_FLAG_Z] = (diff[7:0] == `IEX_ZERO8);
      nxt_flags[`IEX_FLAG_S] = diff[7];
      nxt_flags[`IEX_FLAG_V] = (d[7] ^ s[7]) & (diff[7] ^ d[7]);
      nxt_flags[`IEX_FLAG_D] = 1'b1;
      nxt_flags[`IEX_FLAG_H] = hdiff[4];
    end else if (opcode_i == `IEX_OP_SWAP_D || opcode_i == `IEX_OP_SWAP_P) begin
      nxt_res = {8'h00, d[3:0], d[7:4]};
      nxt_dst_wr = 1'b1;
      nxt_flg_wr = 1'b1;
      nxt_fcyc = `IEX_CYC_2;
      nxt_ecyc = odd_form ? `IEX_CYC_3 : `IEX_CYC_2;
      nxt_flags[`IEX_FLAG_Z] = (d == `IEX_ZERO8);
      nxt_flags[`IEX_FLAG_S] = d[3];
      nxt_flags[`IEX_FLAG_C] = flags_i[`IEX_FLAG_C];
    end else if ((opcode_i >= `IEX_OP_TCPL_FIRST && opcode_i <= `IEX_OP_WTCPL_WL) ||
                 (opcode_i >= `IEX_OP_TMSK_FIRST && opcode_i <= `IEX_OP_WTMSK_WL)) begin
      mask = (opcode_i <= `IEX_OP_WTCPL_WL) ? (~d & s) : (d & s);
      nxt_flg_wr = 1'b1;
      nxt_flags[`IEX_FLAG_Z] = (mask == `IEX_ZERO8);
      nxt_flags[`IEX_FLAG_S] = mask[7];
      nxt_flags[`IEX_FLAG_V] = 1'b0;
      nxt_dst_wr = 1'b0;
      nxt_ecyc = odd_form ? `IEX_CYC_4 : `IEX_CYC_3;
      nxt_fcyc = short_form ? `IEX_CYC_2 : `IEX_CYC_3;
      if (opcode_i[3]) begin
        nxt_fcyc = `IEX_CYC_4;
        nxt_ecyc = `IEX_CYC_3;
      end
    end else if (opcode_i == `IEX_OP_VCALL) begin
      nxt_vcall = 1'b1;
      nxt_fcyc = `IEX_CYC_2;
      nxt_ecyc = `IEX_CYC_6;
    end else begin
      nxt_legal = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire accept = (state_ff == `IEX_ST_IDLE) & req_i;
  wire finish = (state_ff == `IEX_ST_EXEC) & (cnt_ff == `IEX_CYC_0);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= `IEX_ST_IDLE;
      cnt_ff <= `IEX_CYC_0;
      vcall_ff <= 1'b0;
      push_ff <= 1'b0;
      dst_wr_ff <= 1'b0;
      word_wr_ff <= 1'b0;
      flg_wr_ff <= 1'b0;
      old_flags_ff <= `IEX_ZERO8;
      old_pc_ff <= `IEX_ZERO16;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      fetch_cyc_o <= `IEX_CYC_0;
      exec_cyc_o <= `IEX_CYC_0;
      result_o <= `IEX_ZERO16;
      dst_we_o <= 1'b0;
      word_we_o <= 1'b0;
      flags_o <= `IEX_ZERO8;
      flags_we_o <= 1'b0;
      pc_o <= `IEX_ZERO16;
      pc_we_o <= 1'b0;
      sp_o <= `IEX_ZERO16;
      sp_we_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `IEX_ZERO16;
      mem_data_o <= `IEX_ZERO8;
    end else begin
      done_o <= finish;
      dst_we_o <= finish & dst_wr_ff;
      word_we_o <= finish & word_wr_ff;
      flags_we_o <= finish & flg_wr_ff;
      pc_we_o <= finish & vcall_ff;
      sp_we_o <= finish & (vcall_ff | push_ff);
      mem_we_o <= 1'b0;
      if (accept && nxt_legal) begin
        state_ff <= `IEX_ST_EXEC;
        busy_o <= 1'b1;
        illegal_o <= 1'b0;
        cnt_ff <= nxt_ecyc - `IEX_CYC_1;
        vcall_ff <= nxt_vcall;
        push_ff <= nxt_push;
        dst_wr_ff <= nxt_dst_wr;
        word_wr_ff <= nxt_word_wr;
        flg_wr_ff <= nxt_flg_wr;
        old_flags_ff <= flags_i;
        old_pc_ff <= pc_i;
        fetch_cyc_o <= nxt_fcyc;
        exec_cyc_o <= nxt_ecyc;
        result_o <= nxt_res;
        flags_o <= nxt_flags;
        pc_o <= vector_pc_i;
        sp_o <= nxt_vcall ? (sp_i - `IEX_SP_STEP3) : (sp_i - `IEX_SP_STEP1);
        mem_data_o <= s;
      end else if (accept) begin
        illegal_o <= 1'b1;
      end else if (state_ff == `IEX_ST_EXEC) begin
        cnt_ff <= cnt_ff - `IEX_CYC_1;
        // stack writes of the vector call and the literal push
        if (vcall_ff && cnt_ff == `IEX_SLOT_PCL) begin
          mem_we_o <= 1'b1;
          mem_addr_o <= sp_o + `IEX_SP_STEP2;
          mem_data_o <= old_pc_ff[7:0];
        end else if (vcall_ff && cnt_ff == `IEX_SLOT_PCH) begin
          mem_we_o <= 1'b1;
          mem_addr_o <= sp_o + `IEX_SP_STEP1;
          mem_data_o <= old_pc_ff[15:8];
        end else if (vcall_ff && cnt_ff == `IEX_SLOT_FLAGS) begin
          mem_we_o <= 1'b1;
          mem_addr_o <= sp_o;
          mem_data_o <= old_flags_ff;
        end else if (push_ff && cnt_ff == `IEX_SLOT_PUSH) begin
          mem_we_o <= 1'b1;
          mem_addr_o <= sp_o;
        end
        if (finish) begin
          state_ff <= `IEX_ST_IDLE;
          busy_o <= 1'b0;
        end
      end
    end
  end

endmodule // iex_exec

// *** tb/iex_exec_sva.sv ***
// assertion checker of the instruction execute unit
`timescale 1ns/1ps
`include "iex_exec_regs.vh"

module iex_exec_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // request
  input wire req_i,
  input wire prefix_i,
  input wire [7:0] opcode_i,
  input wire [15:0] dst_i,
  input wire [15:0] src_i,
  input wire [7:0] flags_i,
  input wire [15:0] sp_i,
  // results
  input wire busy_o,
  input wire done_o,
  input wire [2:0] exec_cyc_o,
  input wire [15:0] result_o,
  input wire dst_we_o,
  input wire [7:0] flags_o,
  input wire flags_we_o,
  input wire pc_we_o,
  input wire mem_we_o,
  input wire [15:0] mem_addr_o,
  input wire [7:0] mem_data_o
);
  reg pre_ff;
  reg [7:0] op_ff, d_ff, f_ff, m_ff;
  reg [15:0] sp_ff;
  reg [2:0] cnt_ff;
  wire first = done_o && !pre_ff;
  wire is_mask = first && op_ff[7:5] == 3'h3 && op_ff[3:0] > 4'h1 && op_ff[3:0] < 4'ha;
  // ----------------------------------------
  // operands held from the accept edge
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {pre_ff, op_ff, d_ff, f_ff, m_ff, sp_ff, cnt_ff} <= 'd0;
    end else begin
      cnt_ff <= busy_o ? cnt_ff + 3'h1 : 3'h0;
      if (req_i && !busy_o) begin
        {pre_ff, op_ff, d_ff, f_ff, sp_ff} <= {prefix_i, opcode_i, dst_i[7:0], flags_i, sp_i};
        m_ff <= (opcode_i[4] ? dst_i[7:0] : ~dst_i[7:0]) & src_i[7:0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_vcall_take;
    req_i && !busy_o && !prefix_i && opcode_i == `IEX_OP_VCALL;
  endsequence
  sequence s_vcall_writes;
    mem_we_o && mem_addr_o == sp_ff - 16'h0001 ##1 mem_we_o && mem_addr_o == sp_ff - 16'h0002
      ##1 mem_we_o && mem_addr_o == sp_ff - 16'h0003 && mem_data_o == f_ff;
  endsequence
  a_busy_length: assert property (done_o |-> cnt_ff == exec_cyc_o)
    else $error("busy length differs from execute count");
  a_sub_decimal: assert property (first && op_ff[7:1] == 7'h14 |-> dst_we_o && flags_we_o && flags_o[3])
    else $error("subtract write or decimal flag wrong");
  a_swap_halves: assert property (first && op_ff[7:1] == 7'h78 |-> result_o[7:0] == {d_ff[3:0], d_ff[7:4]})
    else $error("nibble exchange result wrong");
  a_swap_flags: assert property (first && op_ff[7:1] == 7'h78 |-> flags_o[6] == (result_o[7:0] == 8'h00)
    && flags_o[3:2] == f_ff[3:2])
    else $error("nibble exchange flags wrong");
  a_mask_flags: assert property (is_mask |-> flags_o[6] == (m_ff == 8'h00) && flags_o[5] == m_ff[7]
    && !flags_o[4] && flags_o[7] == f_ff[7])
    else $error("mask test flags wrong");
  a_mask_keeps_dst: assert property (is_mask |-> !dst_we_o)
    else $error("mask test wrote destination");
  a_vcall_stack: assert property (s_vcall_take |-> ##[1:2] s_vcall_writes)
    else $error("vector call stack writes wrong");
  a_vcall_no_flags: assert property (first && op_ff == `IEX_OP_VCALL |-> pc_we_o && !flags_we_o)
    else $error("vector call flag or pc write wrong");
  a_shift_right: assert property (done_o && pre_ff && op_ff[7:1] == 7'h60 |-> result_o[7:0] == {1'b0, d_ff[7:1]}
    && flags_o[7] == d_ff[0])
    else $error("right shift wrong");
endmodule // iex_exec_sva

bind iex_exec iex_exec_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .prefix_i(prefix_i),
  .opcode_i(opcode_i), .dst_i(dst_i), .src_i(src_i), .flags_i(flags_i), .sp_i(sp_i), .busy_o(busy_o),
  .done_o(done_o), .exec_cyc_o(exec_cyc_o), .result_o(result_o), .dst_we_o(dst_we_o), .flags_o(flags_o),
  .flags_we_o(flags_we_o), .pc_we_o(pc_we_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
  .mem_data_o(mem_data_o));

// *** tb/iex_exec_tb.sv ***
// self-checking testbench of the instruction execute unit
`timescale 1ns/1ps

module iex_exec_tb;
  logic clk_i, rst_b_i, req_i, prefix_i;
  logic [7:0] opcode_i, flags_i;
  logic [15:0] dst_i, src_i, pc_i, sp_i, vector_pc_i;
  wire busy_o, done_o, illegal_o, dst_we_o, word_we_o, flags_we_o, pc_we_o, sp_we_o, mem_we_o;
  wire [2:0] fetch_cyc_o, exec_cyc_o;
  wire [15:0] result_o, pc_o, sp_o, mem_addr_o;
  wire [7:0] flags_o, mem_data_o;
  int mismatches, comparisons, cycles, nw;
  logic [15:0] wa [0:3];
  logic [7:0] wd [0:3];
  iex_exec uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .prefix_i(prefix_i), .opcode_i(opcode_i),
    .dst_i(dst_i), .src_i(src_i), .flags_i(flags_i), .pc_i(pc_i), .sp_i(sp_i), .vector_pc_i(vector_pc_i),
    .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .fetch_cyc_o(fetch_cyc_o), .exec_cyc_o(exec_cyc_o),
    .result_o(result_o), .dst_we_o(dst_we_o), .word_we_o(word_we_o), .flags_o(flags_o), .flags_we_o(flags_we_o),
    .pc_o(pc_o), .pc_we_o(pc_we_o), .sp_o(sp_o), .sp_we_o(sp_we_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o));
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // issue one instruction, wait for done, record stack writes
  task run(input logic p, input [7:0] op, input [15:0] d, s, input [7:0] f, input [2:0] fc, ec);
    int k;
    {prefix_i, opcode_i, dst_i, src_i, flags_i, req_i} = {p, op, d, s, f, 1'b1};
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    k = 0;
    nw = 0;
    while (done_o !== 1'b1 && k < 12) begin
      if (mem_we_o === 1'b1 && nw < 4) begin
        wa[nw] = mem_addr_o;
        wd[nw] = mem_data_o;
        nw++;
      end
      @(posedge clk_i);
      #1;
      k++;
    end
    chk(k == ec && fetch_cyc_o === fc && exec_cyc_o === ec, "cycle counts");
  endtask
  task t_illegal;
    {prefix_i, opcode_i, req_i} = {1'b1, 8'h28, 1'b1};
    @(posedge clk_i);
    #1;
    chk(illegal_o === 1'b1 && busy_o === 1'b0, "first-table opcode after prefix");
    {prefix_i, opcode_i} = {1'b0, 8'hc0};
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    chk(illegal_o === 1'b1 && busy_o === 1'b0, "second-table opcode without prefix");
    @(posedge clk_i);
    #1;
    $display("t_illegal end");
  endtask
  // cut a vector call by reset, nothing may resume afterwards
  task t_reset;
    {prefix_i, opcode_i, sp_i, req_i} = {1'b0, 8'hf2, 16'h0300, 1'b1};
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    @(posedge clk_i);
    #1;
    rst_b_i = 1'b0;
    #1;
    chk({busy_o, done_o, illegal_o, mem_we_o} === 4'h0 && sp_o === 16'h0000 && pc_o === 16'h0000, "in reset");
    @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({busy_o, done_o, mem_we_o, pc_we_o, sp_we_o} === 5'h00, "resumed after reset");
    $display("t_reset end");
  endtask
  task t_wsub;
    run(1'b0, 8'h28, 16'h0010, 16'h0020, 8'h00, 3'h4, 3'h3);
    chk(illegal_o === 1'b0 && dst_we_o === 1'b1 && result_o[7:0] === 8'hf0, "sub");
    chk(flags_o === 8'ha8 && flags_we_o === 1'b1, "sub flags");
    run(1'b0, 8'h29, 16'h0080, 16'h0001, 8'h03, 3'h4, 3'h3);
    chk(result_o[7:0] === 8'h7f && flags_o === 8'h1f, "sub imm");
    $display("t_wsub end");
  endtask
  task t_swap;
    run(1'b0, 8'hf0, 16'h00a5, 16'h0000, 8'h0c, 3'h2, 3'h2);
    chk(result_o[7:0] === 8'h5a && flags_o[6:5] === 2'b00 && flags_o[3:2] === 2'b11, "swap");
    chk(dst_we_o === 1'b1 && flags_we_o === 1'b1, "swap write");
    run(1'b0, 8'hf1, 16'h0000, 16'h0000, 8'h00, 3'h2, 3'h3);
    chk(result_o[7:0] === 8'h00 && flags_o[6:5] === 2'b10 && flags_o[3:2] === 2'b00, "swap zero");
    $display("t_swap end");
  endtask
  task t_mask;
    logic [7:0] op;
    logic [2:0] fc, ec;
    for (int n = 0; n < 16; n++) begin
      op = {(n < 8) ? 4'h6 : 4'h7, {1'b0, n[2:0]} + 4'h2};
      fc = (op[3:0] > 4'h7) ? 3'h4 : ((op[3:0] > 4'h3) ? 3'h3 : 3'h2);
      ec = (op[3:0] > 4'h7) ? 3'h3 : 3'h3 + {2'b00, op[0]};
      run(1'b0, op, 16'h000f, (n < 8) ? 16'h008f : 16'h00f0, 8'h9c, fc, ec);
      chk(dst_we_o === 1'b0 && flags_we_o === 1'b1, "mask write");
      chk(flags_o === ((n < 8) ? 8'hac : 8'hcc), "mask flags");
    end
    $display("t_mask end");
  endtask
  task t_vcall;
    {pc_i, sp_i, vector_pc_i} = {16'h1234, 16'h0300, 16'h4567};
    run(1'b0, 8'hf2, 16'h0000, 16'h0000, 8'h5a, 3'h2, 3'h6);
    chk(nw == 3 && wa[0] === 16'h02ff && wd[0] === 8'h34 && wa[1] === 16'h02fe && wd[1] === 8'h12, "pc");
    chk(wa[2] === 16'h02fd && wd[2] === 8'h5a && sp_o === 16'h02fd && sp_we_o === 1'b1, "flag push");
    chk(pc_o === 16'h4567 && pc_we_o === 1'b1 && flags_we_o === 1'b0, "vector");
    $display("t_vcall end");
  endtask
  task t_prefix;
    run(1'b1, 8'hc0, 16'h0081, 16'h0000, 8'h00, 3'h3, 3'h2);
    chk(result_o[7:0] === 8'h40 && flags_o === 8'h80 && dst_we_o === 1'b1, "shift");
    run(1'b1, 8'hc1, 16'h0001, 16'h0000, 8'h0c, 3'h3, 3'h3);
    chk(result_o[7:0] === 8'h00 && flags_o === 8'hcc, "shift zero");
    run(1'b1, 8'ha2, 16'h0005, 16'h0005, 8'h40, 3'h3, 3'h3);
    chk(flags_o === 8'h40 && dst_we_o === 1'b0, "cmpc");
    run(1'b1, 8'ha3, 16'h0005, 16'h0004, 8'h80, 3'h3, 3'h4);
    chk(flags_o === 8'h00, "cmpc z");
    for (int n = 0; n < 2; n++) begin
      run(1'b1, 8'ha8 + n[7:0], 16'h0000, 16'h0000, 8'h80, 3'h5, 3'h3);
      chk(flags_o === 8'ha0, "wide cmpc");
    end
    sp_i = 16'h0200;
    run(1'b1, 8'h70, 16'h0000, 16'h003c, 8'h00, 3'h3, 3'h2);
    chk(nw == 1 && wa[0] === 16'h01ff && wd[0] === 8'h3c && sp_o === 16'h01ff && sp_we_o === 1'b1, "push");
    run(1'b1, 8'he8, 16'h0000, 16'hbeef, 8'h00, 3'h5, 3'h4);
    chk(result_o === 16'hbeef && word_we_o === 1'b1, "word load");
    $display("t_prefix end");
  endtask
  task results;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results;
    end
  end
  initial begin
    {rst_b_i, req_i, prefix_i, opcode_i, flags_i} = 'd0;
    {dst_i, src_i, pc_i, sp_i, vector_pc_i} = 'd0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    t_illegal;
    t_wsub;
    t_swap;
    t_mask;
    t_vcall;
    t_reset;
    t_prefix;
    results;
  end
endmodule // iex_exec_tb
